// ===== rtl/pbm_pkg.sv
package pbm_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int PIN_BASE = 3;
    localparam int PIN_CNT = 5;
    localparam int KEY_CNT = 4;
    localparam int STAT_W = 2;

    typedef logic [ADDR_W-1:0] pbm_addr_t;
    typedef logic [REG_W-1:0] pbm_reg_t;

    // Register byte addresses.
    localparam pbm_addr_t OFF_LEVELS = 8'h00;
    localparam pbm_addr_t OFF_LATCH = 8'h04;
    localparam pbm_addr_t OFF_DIR = 8'h08;
    localparam pbm_addr_t OFF_CTL_MAIN = 8'h0C;
    localparam pbm_addr_t OFF_CTL_SECOND = 8'h10;
    localparam pbm_addr_t OFF_CTL_THIRD = 8'h14;
    localparam pbm_addr_t OFF_OPEN_DRAIN = 8'h18;
    localparam pbm_addr_t OFF_IRQ_STAT = 8'h1C;
    localparam pbm_addr_t OFF_IRQ_MASK = 8'h20;

    // Field positions.
    localparam int B_CHG_FLAG = 0;
    localparam int B_CHG_EN = 3;
    localparam int B_PUD_N = 7;
    localparam int B_EDGE3 = 3;
    localparam int B_EXT3_PRIO = 1;
    localparam int B_CHG_PRIO = 0;
    localparam int B_EXT3_EN = 5;
    localparam int B_EXT3_FLAG = 2;
    localparam int B_CCP2_OD = 6;
    localparam int S_CHG = 0;
    localparam int S_EXT3 = 1;

    // Pin indices inside the five-pin slice, pin 3 first.
    localparam int I_PIN3 = 0;
    localparam int I_PIN5 = 2;
    localparam int I_PIN6 = 3;
    localparam int I_PIN7 = 4;
    localparam int KEY_LO = 1;

    localparam pbm_reg_t RST_LATCH = 8'h00;
    localparam pbm_reg_t RST_DIR = 8'hFF;
    localparam pbm_reg_t RST_CTL_SECOND = 8'h80;
    localparam pbm_reg_t RST_ZERO = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/pbm_sync_if.sv
`timescale 1ns/1ps
interface pbm_sync_if #(parameter int W = 5);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport syncer (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// ===== rtl/pbm_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a level is accepted once stages two and
// three agree, so a single-cycle disagreement never reaches the port logic.
module pbm_pin_sync #(
    parameter int W = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    pbm_sync_if.syncer sif
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] clean_ff;

    if (W < 1) begin : g_bad_width
        $error("pbm_pin_sync needs at least one pin");
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= sif.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clean_ff <= '0;
        end else begin
            clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
        end
    end

    assign sif.clean = clean_ff;

endmodule // pbm_pin_sync

// ===== rtl/pbm_port_b_upper.sv
`timescale 1ns/1ps
// What this block does
// - Direction one makes an input, readable; pull-up only while disable clear.
// - Mapped channel with direction zero drives pin 3 instead of latch.
// - PWM A on pin 3 may tri-state during shutdown; beats port data.
// - Channel maps to pin 3 only with select clear and extended mode.
// - Pin 3 as input feeds external interrupt line 3.
// - Pin 5 feeds timer one gate and timer three clock always.
// - Don't-care alternate inputs ignore the direction bit.
// - In programming mode pin 6 is the serial clock input.
// - In programming mode pin 7 drives data out when transmitting.
// - In programming mode pin 7 takes data in when not transmitting.
// - Clearing the disable bit enables pull-ups; outputs lose theirs.
// - Pull-ups are disabled after reset.
// - Input pins 4 to 7 compared with last level read or write; mismatch sets flag.
// - Mismatch keeps setting flag; port access ends it.
module pbm_port_b_upper
    import pbm_pkg::*;
#(
    parameter int ADDR_WIDTH = pbm_pkg::ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pbm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pbm_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pbm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pbm_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [pbm_pkg::PIN_CNT-1:0] pin_in,
    output logic [pbm_pkg::PIN_CNT-1:0] pin_out,
    output logic [pbm_pkg::PIN_CNT-1:0] pin_oe,
    output logic [pbm_pkg::PIN_CNT-1:0] pin_pullup,
    input wire logic ccp_two_out,
    input wire logic ccp_two_pin_select,
    input wire logic ext_mcu_mode,
    input wire logic pwm_shutdown,
    input wire logic pwm_shutdown_tristate,
    input wire logic prog_mode,
    input wire logic prog_data_drive,
    input wire logic prog_data_out,
    output logic ccp_two_capture_in,
    output logic charge_unit_edge2_in,
    output logic ext_irq3_input,
    output logic key_change_in0,
    output logic key_change_in1,
    output logic key_change_in2,
    output logic key_change_in3,
    output logic timer_three_clock_in,
    output logic timer_one_gate_in,
    output logic prog_serial_clock,
    output logic prog_serial_data,
    output logic port_change_flag,
    output logic ext_irq3_flag,
    output logic irq
);
    import pbm_pkg::*;

    if (ADDR_WIDTH != ADDR_W) begin : g_bad_addr
        $error("pbm_port_b_upper supports only the package address width");
    end

    pbm_sync_if #(.W(PIN_CNT)) sif ();

    pbm_pin_sync #(.W(PIN_CNT)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(sif)
    );

    assign sif.raw = pin_in;

    // Bus handshake state.
    logic awready_ff;
    logic wready_ff;
    logic aw_got_ff;
    logic w_got_ff;
    pbm_addr_t waddr_ff;
    logic [REG_W-1:0] wdata_ff;
    logic wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_wr;
    logic do_rd;
    logic nxt_aw_got;
    logic nxt_w_got;
    logic nxt_rvalid;

    // Software registers.
    pbm_reg_t lat_ff;
    pbm_reg_t dir_ff;
    logic chg_en_ff;
    pbm_reg_t ctl2_ff;
    logic ext3_en_ff;
    logic ccp_od_ff;
    logic [STAT_W-1:0] stat_ff;
    logic [STAT_W-1:0] mask_ff;
    logic [KEY_CNT-1:0] old_ff;

    // Pin and tap state.
    logic [PIN_CNT-1:0] out_ff;
    logic [PIN_CNT-1:0] oe_ff;
    logic [PIN_CNT-1:0] pull_ff;
    logic [PIN_CNT-1:0] nxt_out;
    logic [PIN_CNT-1:0] nxt_oe;
    logic [PIN_CNT-1:0] nxt_pull;
    logic ccp_cap_ff;
    logic edge2_ff;
    logic ext3_ff;
    logic ext3_d_ff;
    logic [KEY_CNT-1:0] key_ff;
    logic t3_ff;
    logic t1g_ff;
    logic pgc_ff;
    logic pgd_ff;
    logic irq_ff;

    logic [PIN_CNT-1:0] clean;
    logic [PIN_CNT-1:0] pin_dir;
    logic [KEY_CNT-1:0] key_dir;
    logic ccp_mapped;
    logic mismatch;
    logic ext3_edge;
    logic wr_ok;
    logic [DATA_W-1:0] rd_word;
    logic rd_ok;

    function automatic logic is_mapped(input pbm_addr_t a);
        is_mapped = (a == OFF_LEVELS) || (a == OFF_LATCH) ||
            (a == OFF_DIR) || (a == OFF_CTL_MAIN) ||
            (a == OFF_CTL_SECOND) || (a == OFF_CTL_THIRD) ||
            (a == OFF_OPEN_DRAIN) || (a == OFF_IRQ_STAT) ||
            (a == OFF_IRQ_MASK);
    endfunction

    assign clean = sif.clean;
    assign pin_dir = dir_ff[PIN_BASE +: PIN_CNT];
    assign key_dir = dir_ff[PIN_BASE + KEY_LO +: KEY_CNT];
    assign ccp_mapped = !ccp_two_pin_select && ext_mcu_mode;

    // Write address and data are taken independently; the write happens
    // once both are held and no response is pending.
    assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_ok = do_wr && wstrb_ff;
    assign do_rd = s_axi_arvalid && arready_ff;
    assign nxt_aw_got = do_wr ? 1'b0 :
        (aw_got_ff || (s_axi_awvalid && awready_ff));
    assign nxt_w_got = do_wr ? 1'b0 :
        (w_got_ff || (s_axi_wvalid && wready_ff));
    assign nxt_rvalid = do_rd || (rvalid_ff && !s_axi_rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= 1'b0;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awready_ff <= !nxt_aw_got;
            wready_ff <= !nxt_w_got;
            if (s_axi_awvalid && awready_ff) begin
                waddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff <= s_axi_wdata[REG_W-1:0];
                wstrb_ff <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= is_mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read data; pins 0 to 2 are outside this block and read as zero in the level register.
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            OFF_LEVELS: rd_word[PIN_BASE +: PIN_CNT] = clean;
            OFF_LATCH: rd_word[REG_W-1:0] = lat_ff;
            OFF_DIR: rd_word[REG_W-1:0] = dir_ff;
            OFF_CTL_MAIN: begin
                rd_word[B_CHG_EN] = chg_en_ff;
                rd_word[B_CHG_FLAG] = stat_ff[S_CHG];
            end
            OFF_CTL_SECOND: rd_word[REG_W-1:0] = ctl2_ff;
            OFF_CTL_THIRD: begin
                rd_word[B_EXT3_EN] = ext3_en_ff;
                rd_word[B_EXT3_FLAG] = stat_ff[S_EXT3];
            end
            OFF_OPEN_DRAIN: rd_word[B_CCP2_OD] = ccp_od_ff;
            OFF_IRQ_STAT: rd_word[STAT_W-1:0] = stat_ff;
            OFF_IRQ_MASK: rd_word[STAT_W-1:0] = mask_ff;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= !nxt_rvalid;
            if (do_rd) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Writes to either the level or the latch address land in the latch.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_ff <= RST_LATCH;
            dir_ff <= RST_DIR;
            chg_en_ff <= 1'b0;
            ctl2_ff <= RST_CTL_SECOND;
            ext3_en_ff <= 1'b0;
            ccp_od_ff <= 1'b0;
            mask_ff <= '0;
        end else if (wr_ok) begin
            case (waddr_ff)
                OFF_LEVELS: lat_ff <= wdata_ff;
                OFF_LATCH: lat_ff <= wdata_ff;
                OFF_DIR: dir_ff <= wdata_ff;
                OFF_CTL_MAIN: chg_en_ff <= wdata_ff[B_CHG_EN];
                OFF_CTL_SECOND: ctl2_ff <= wdata_ff;
                OFF_CTL_THIRD: ext3_en_ff <= wdata_ff[B_EXT3_EN];
                OFF_OPEN_DRAIN: ccp_od_ff <= wdata_ff[B_CCP2_OD];
                OFF_IRQ_MASK: mask_ff <= wdata_ff[STAT_W-1:0];
                default: ;
            endcase
        end
    end

    // Change detection: any read of the level register, or a write to it with byte strobe 0 set, re-arms the
    // reference so that a standing mismatch ends on the next cycle.
    assign mismatch = |((clean[KEY_LO +: KEY_CNT] ^ old_ff) & key_dir);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            old_ff <= '0;
        end else if ((do_rd && s_axi_araddr == OFF_LEVELS) ||
                (wr_ok && waddr_ff == OFF_LEVELS)) begin
            old_ff <= clean[KEY_LO +: KEY_CNT];
        end
    end

    assign ext3_edge = ctl2_ff[B_EDGE3] ? (ext3_ff && !ext3_d_ff) :
        (!ext3_ff && ext3_d_ff);

    // Status bits are write-one-to-clear; a new event in the same cycle wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_ff <= '0;
        end else begin
            for (int i = 0; i < STAT_W; i++) begin
                if (wr_ok && waddr_ff == OFF_IRQ_STAT && wdata_ff[i]) begin
                    stat_ff[i] <= 1'b0;
                end
            end
            if (mismatch) begin
                stat_ff[S_CHG] <= 1'b1;
            end
            if (ext3_edge) begin
                stat_ff[S_EXT3] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    // Pin drive: latch by default, then the channel, then programming mode.
    always_comb begin
        nxt_oe = ~pin_dir;
        nxt_out = lat_ff[PIN_BASE +: PIN_CNT];
        if (ccp_mapped && !pin_dir[I_PIN3]) begin
            if (pwm_shutdown && pwm_shutdown_tristate) begin
                nxt_oe[I_PIN3] = 1'b0;
            end else if (ccp_od_ff) begin
                nxt_out[I_PIN3] = 1'b0;
                nxt_oe[I_PIN3] = !ccp_two_out;
            end else begin
                nxt_out[I_PIN3] = ccp_two_out;
            end
        end
        if (prog_mode) begin
            nxt_oe[I_PIN6] = 1'b0;
            nxt_oe[I_PIN7] = prog_data_drive;
            nxt_out[I_PIN7] = prog_data_out;
        end
        nxt_pull = ~nxt_oe & {PIN_CNT{!ctl2_ff[B_PUD_N]}};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= '0;
            oe_ff <= '0;
            pull_ff <= '0;
        end else begin
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            pull_ff <= nxt_pull;
        end
    end

    // Input taps toward the peripherals.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ccp_cap_ff <= 1'b0;
            edge2_ff <= 1'b0;
            ext3_ff <= 1'b0;
            ext3_d_ff <= 1'b0;
            key_ff <= '0;
            t3_ff <= 1'b0;
            t1g_ff <= 1'b0;
            pgc_ff <= 1'b0;
            pgd_ff <= 1'b0;
        end else begin
            ccp_cap_ff <= ccp_mapped && pin_dir[I_PIN3] && clean[I_PIN3];
            edge2_ff <= clean[I_PIN3];
            ext3_ff <= pin_dir[I_PIN3] && clean[I_PIN3];
            ext3_d_ff <= ext3_ff;
            key_ff <= clean[KEY_LO +: KEY_CNT] & key_dir;
            t3_ff <= clean[I_PIN5];
            t1g_ff <= clean[I_PIN5];
            pgc_ff <= prog_mode && clean[I_PIN6];
            pgd_ff <= prog_mode && !prog_data_drive && clean[I_PIN7];
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign pin_out = out_ff;
    assign pin_oe = oe_ff;
    assign pin_pullup = pull_ff;
    assign ccp_two_capture_in = ccp_cap_ff;
    assign charge_unit_edge2_in = edge2_ff;
    assign ext_irq3_input = ext3_ff;
    assign key_change_in0 = key_ff[0];
    assign key_change_in1 = key_ff[1];
    assign key_change_in2 = key_ff[2];
    assign key_change_in3 = key_ff[3];
    assign timer_three_clock_in = t3_ff;
    assign timer_one_gate_in = t1g_ff;
    assign prog_serial_clock = pgc_ff;
    assign prog_serial_data = pgd_ff;
    assign port_change_flag = stat_ff[S_CHG];
    assign ext_irq3_flag = stat_ff[S_EXT3];
    assign irq = irq_ff;

    a_input_no_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(pin_dir[1]) |-> !oe_ff[1])
        else $error("pin 4 driven while set as input");

    a_ccp_drives: assert property (@(posedge aclk) disable iff (!aresetn)
        ccp_mapped && !pin_dir[I_PIN3] && !pwm_shutdown && !ccp_od_ff &&
        !prog_mode |=> oe_ff[I_PIN3] && out_ff[I_PIN3] == $past(ccp_two_out))
        else $error("channel output not on pin 3");

    a_pwm_tristate: assert property (@(posedge aclk) disable iff (!aresetn)
        ccp_mapped && !pin_dir[I_PIN3] && pwm_shutdown &&
        pwm_shutdown_tristate |=> !oe_ff[I_PIN3])
        else $error("pin 3 still driven during shutdown");

    a_ccp_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
        !ccp_mapped && !pin_dir[I_PIN3] |=>
        oe_ff[I_PIN3] && out_ff[I_PIN3] == $past(lat_ff[PIN_BASE]))
        else $error("pin 3 not from latch when channel unmapped");

    a_timer_tap: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(clean[I_PIN5]) |=> timer_three_clock_in && timer_one_gate_in)
        else $error("pin 5 rise missing on timer taps");

    a_prog_clock_in: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_mode |=> !oe_ff[I_PIN6] && pgc_ff == $past(clean[I_PIN6]))
        else $error("pin 6 not serial clock input");

    a_prog_data_out: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_mode && prog_data_drive |=>
        oe_ff[I_PIN7] && out_ff[I_PIN7] == $past(prog_data_out))
        else $error("pin 7 not driving serial data");

    a_prog_data_in: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_mode && !prog_data_drive |=> !oe_ff[I_PIN7])
        else $error("pin 7 driven while programmer sends");

    a_pullup_output: assert property (@(posedge aclk) disable iff (!aresetn)
        (oe_ff & pull_ff) == '0)
        else $error("pull-up on while pin drives");

    a_pullup_reset: assert property (@(posedge aclk)
        !aresetn |=> pull_ff == '0)
        else $error("pull-ups on straight after reset");

    a_change_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        mismatch |=> stat_ff[S_CHG] [*1] ##1 stat_ff[S_CHG] || !mismatch)
        else $error("mismatch did not set change flag");

    a_latch_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ok && waddr_ff == OFF_LATCH |=> lat_ff == $past(wdata_ff))
        else $error("latch write lost");

endmodule // pbm_port_b_upper

// ===== test/pbm_pin_model.sv
`timescale 1ns/1ps
// Board side of the five pins. The block's driver wins, then an outside
// driver, then the pull-up; a floating pin toggles every cycle.
module pbm_pin_model (
    input wire logic aclk,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pin_pullup,
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_val,
    output logic [4:0] pin_in
);
    logic [4:0] float_ff = 5'h00;
    always_ff @(posedge aclk) begin
        float_ff <= ~float_ff;
    end
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'h1;
            end else begin
                pin_in[i] = float_ff[i];
            end
        end
    end
endmodule // pbm_pin_model

// ===== test/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
    end \
end

module tb;
    import pbm_pkg::*;
    logic aclk;
    logic aresetn = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
    pbm_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [4:0] ext_en = 5'h00, ext_val = 5'h00;
    logic ccp_two_out = 1'h0, ccp_two_pin_select = 1'h1, ext_mcu_mode = 1'h0;
    logic pwm_shutdown = 1'h0, pwm_shutdown_tristate = 1'h0, prog_mode = 1'h0;
    logic prog_data_drive = 1'h0, prog_data_out = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ccp_two_capture_in, charge_unit_edge2_in;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, wresp, rresp;
    logic [4:0] pin_in, pin_out, pin_oe, pin_pullup;
    logic ext_irq3_input, key_change_in0, key_change_in1, key_change_in2;
    logic key_change_in3, timer_three_clock_in, timer_one_gate_in;
    logic prog_serial_clock, prog_serial_data, port_change_flag;
    logic ext_irq3_flag, irq;
    pbm_reg_t rdat;
    int err_total = 0;
    int total_checks = 0;

    pbm_port_b_upper u_dut (.*);
    pbm_pin_model u_pins (.aclk, .pin_out, .pin_oe, .pin_pullup, .ext_en,
        .ext_val, .pin_in);

    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic summarize();
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge aclk);
        err_total++;
        summarize();
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input pbm_addr_t a, input logic [7:0] d);
        logic aw;
        logic w;
        aw = 1'h0;
        w = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'h1) begin
                aw = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w && s_axi_wready === 1'h1) begin
                w = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do begin
            @(posedge aclk);
        end while (s_axi_bvalid !== 1'h1);
        wresp = s_axi_bresp;
    endtask

    task automatic rd(input pbm_addr_t a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
        end while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do begin
            @(posedge aclk);
        end while (s_axi_rvalid !== 1'h1);
        rdat = s_axi_rdata[7:0];
        rresp = s_axi_rresp;
    endtask

    task automatic t_reset();
        `CHK(pin_pullup, 5'h00)
        rd(OFF_CTL_SECOND);
        `CHK(rdat, RST_CTL_SECOND)
        wr(8'h44, 8'hFF);
        `CHK(wresp, RESP_SLVERR)
        rd(OFF_LATCH);
        `CHK(rdat, RST_LATCH)
        rd(OFF_DIR);
        `CHK(rdat, RST_DIR)
        rd(8'h44);
        `CHK(rresp, RESP_SLVERR)
        `CHK(rdat, 8'h00)
    endtask

    task automatic t_latch();
        wr(OFF_DIR, 8'h00);
        wr(OFF_LATCH, 8'hA8);
        `CHK(wresp, RESP_OKAY)
        cyc(2);
        `CHK(pin_oe, 5'h1F)
        `CHK(pin_out, 5'h15)
        wr(OFF_LEVELS, 8'h50);
        rd(OFF_LATCH);
        `CHK(rdat, 8'h50)
        wr(OFF_CTL_SECOND, 8'h00);
        cyc(2);
        `CHK(pin_pullup, 5'h00)
        wr(OFF_DIR, 8'hF8);
        cyc(8);
        `CHK(pin_pullup, 5'h1F)
        rd(OFF_LEVELS);
        `CHK(rdat[7:3], 5'h1F)
    endtask

    task automatic t_alt();
        wr(OFF_DIR, 8'hD8);
        cyc(8);
        `CHK(timer_one_gate_in, 1'h0)
        wr(OFF_LATCH, 8'h70);
        cyc(8);
        `CHK(timer_three_clock_in, 1'h1)
        ext_en <= 5'h01;
        cyc(8);
        `CHK(ext_irq3_input, 1'h0)
        `CHK(charge_unit_edge2_in, 1'h0)
        `CHK(ext_irq3_flag, 1'h1)
        ext_en <= 5'h00;
        cyc(8);
        `CHK(ext_irq3_input, 1'h1)
    endtask

    task automatic t_change();
        wr(OFF_IRQ_MASK, 8'h01);
        rd(OFF_LEVELS);
        wr(OFF_IRQ_STAT, 8'h03);
        // Pin 5 is an output here, so its change must be ignored.
        wr(OFF_LATCH, 8'h50);
        cyc(8);
        `CHK(irq, 1'h0)
        ext_en <= 5'h02;
        cyc(8);
        `CHK(irq, 1'h1)
        `CHK(key_change_in0, 1'h0)
        `CHK(key_change_in1, 1'h0)
        `CHK(key_change_in2, 1'h1)
        `CHK(key_change_in3, 1'h1)
        `CHK(port_change_flag, 1'h1)
        wr(OFF_IRQ_STAT, 8'h01);
        rd(OFF_IRQ_STAT);
        `CHK(rdat[0], 1'h1)
        rd(OFF_LEVELS);
        cyc(1);
        wr(OFF_IRQ_STAT, 8'h01);
        rd(OFF_IRQ_STAT);
        `CHK(rdat[0], 1'h0)
        `CHK(irq, 1'h0)
        `CHK(port_change_flag, 1'h0)
    endtask

    task automatic t_ccp();
        ext_en <= 5'h00;
        ccp_two_pin_select <= 1'h0;
        ext_mcu_mode <= 1'h1;
        ccp_two_out <= 1'h1;
        wr(OFF_DIR, 8'h00);
        cyc(3);
        `CHK(pin_out[0], 1'h1)
        ext_mcu_mode <= 1'h0;
        cyc(3);
        `CHK(pin_out[0], 1'h0)
        ext_mcu_mode <= 1'h1;
        pwm_shutdown <= 1'h1;
        pwm_shutdown_tristate <= 1'h1;
        cyc(3);
        `CHK(pin_oe[0], 1'h0)
        pwm_shutdown <= 1'h0;
        wr(OFF_DIR, 8'h08);
        cyc(8);
        `CHK(ccp_two_capture_in, 1'h1)
        ext_mcu_mode <= 1'h0;
        cyc(2);
        `CHK(ccp_two_capture_in, 1'h0)
    endtask

    task automatic t_prog();
        prog_mode <= 1'h1;
        ext_en <= 5'h08;
        ext_val <= 5'h08;
        cyc(8);
        `CHK(pin_oe[3], 1'h0)
        `CHK(prog_serial_clock, 1'h1)
        prog_data_drive <= 1'h1;
        prog_data_out <= 1'h1;
        cyc(3);
        `CHK(pin_out[4], 1'h1)
        prog_data_drive <= 1'h0;
        cyc(2);
        ext_en <= 5'h18;
        ext_val <= 5'h18;
        cyc(8);
        `CHK(pin_oe[4], 1'h0)
        `CHK(prog_serial_data, 1'h1)
        ext_val <= 5'h08;
        cyc(8);
        `CHK(prog_serial_data, 1'h0)
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_latch();
        t_alt();
        t_change();
        t_ccp();
        t_prog();
        summarize();
    end
endmodule // tb
